//--- core/dew_top.sv
// Debug enclave write leaf: checks, write, result and flags, Wishbone slave
//
// The Wishbone slave port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module dew_top (
  // Clock and reset
  input  wire logic              MCLK,
  input  wire logic              SYS_RST,
  // Wishbone slave
  input  wire logic              WB_CYC_I,
  input  wire logic              WB_STB_I,
  input  wire logic              WB_WE_I,
  input  wire logic [7:0]        WB_ADR_I,
  input  wire logic [3:0]        WB_SEL_I,
  input  wire logic [31:0]       WB_DAT_I,
  output logic      [31:0]       WB_DAT_O,
  output logic                   WB_ACK_O,
  // Page map lookup (same clock domain)
  output logic      [63:0]       MAP_ADDR,
  input  wire dew_pkg::dew_entry_s MAP_ENTRY,
  input  wire logic              MAP_BUSY,
  input  wire logic              SEG_FAULT,
  output logic                   MAP_SHARED,
  // Enclave memory write
  output logic                   MEM_WR_VALID,
  output dew_pkg::dew_wr_s       MEM_WR,
  input  wire logic              MEM_WR_READY,
  // Results
  output dew_pkg::dew_flags_s    FLAGS,
  output logic                   GP_FAULT,
  output logic                   PF_FAULT,
  output logic      [63:0]       PF_ADDR,
  output logic                   IRQ
);
  import dew_pkg::*;

  // ------------------------------------------------------------
  // State and registers
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_LOOK,
    ST_WRITE
  } dew_state_e;

  dew_state_e       state_q;
  logic [31:0]      leaf_q;
  logic [63:0]      addr_q;
  logic [63:0]      data_q;
  logic [2:0]       mode_q;
  logic [63:0]      result_q;
  dew_flags_s       flags_q;
  logic             gp_q;
  logic             pf_q;
  logic             busy_q;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_en_q;
  logic             ack_q;
  logic [31:0]      rdata_q;
  logic             wr_valid_q;

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  wire        bus_req   = WB_CYC_I & WB_STB_I & ~ack_q;
  // Writes land at the edge that sees ack high, as a classic master expects
  wire        bus_wr    = WB_CYC_I & WB_STB_I & WB_WE_I & ack_q;
  wire        wr_ctrl   = bus_wr & (WB_ADR_I == REG_CTRL);
  wire        wr_leaf   = bus_wr & (WB_ADR_I == REG_LEAF);
  wire        wr_alo    = bus_wr & (WB_ADR_I == REG_ADDR_LO);
  wire        wr_ahi    = bus_wr & (WB_ADR_I == REG_ADDR_HI);
  wire        wr_dlo    = bus_wr & (WB_ADR_I == REG_DATA_LO);
  wire        wr_dhi    = bus_wr & (WB_ADR_I == REG_DATA_HI);
  wire        wr_mode   = bus_wr & (WB_ADR_I == REG_MODE);
  wire        wr_ien    = bus_wr & (WB_ADR_I == REG_IRQ_EN);
  wire        wr_iclr   = bus_wr & (WB_ADR_I == REG_IRQ_CLR);
  // Operand writes during an operation are ignored so the check sees stable inputs
  wire        op_wr_ok  = ~busy_q;
  wire        go        = wr_ctrl & WB_SEL_I[0] & WB_DAT_I[CTRL_GO_BIT] & op_wr_ok;

  // Byte-lane merge for a 32-bit register
  function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Read mux, unmapped addresses read zero
  logic [31:0] rd_mux;
  always_comb begin
    unique case (WB_ADR_I)
      REG_LEAF:      rd_mux = leaf_q;
      REG_ADDR_LO:   rd_mux = addr_q[31:0];
      REG_ADDR_HI:   rd_mux = addr_q[63:32];
      REG_DATA_LO:   rd_mux = data_q[31:0];
      REG_DATA_HI:   rd_mux = data_q[63:32];
      REG_MODE:      rd_mux = {29'h0, mode_q};
      REG_RESULT_LO: rd_mux = result_q[31:0];
      REG_RESULT_HI: rd_mux = result_q[63:32];
      REG_STATUS:    rd_mux = {23'h0, busy_q, pf_q, gp_q, flags_q};
      REG_IRQ_STAT:  rd_mux = {29'h0, irq_stat_q};
      REG_IRQ_EN:    rd_mux = {29'h0, irq_en_q};
      default:       rd_mux = 32'h0000_0000;
    endcase
  end

  // ------------------------------------------------------------
  // Check chain
  // ------------------------------------------------------------
  wire        mode64     = mode_q[MODE_LMA_BIT] & mode_q[MODE_CSL_BIT]; // [R03]
  wire        leaf_ok    = (leaf_q == LEAF_DEBUG_WRITE); // [R01]
  wire        canon_bad  = mode64 &
    (addr_q[63:CANON_BITS-1] != {(65-CANON_BITS){addr_q[CANON_BITS-1]}}); // [R16]
  wire        seg_bad    = ~mode64 & (~mode_q[MODE_DSOK_BIT] | SEG_FAULT); // [R17]
  wire        align_bad  = mode64 ? (addr_q[2:0] != 3'h0)
                                  : (addr_q[1:0] != 2'h0); // [R04]
  wire        not_cache  = ~MAP_ENTRY.in_cache; // [R05]
  wire        conflict   = MAP_BUSY; // [R06]
  wire        invalid    = ~MAP_ENTRY.valid; // [R07]
  wire [2:0]  pt         = MAP_ENTRY.ptype;
  // Control-structure pages fall out here as an unaccepted type
  wire        type_bad   = (pt != PT_REGULAR) & (pt != PT_THREAD) &
                           (pt != SHADOW_STACK_FIRST_TYPE_CODE) & (pt != SHADOW_STACK_REST_TYPE_CODE); // [R08] [R15]
  wire        notdbg     = MAP_ENTRY.pending | MAP_ENTRY.modified; // [R09]
  wire        tcs_bad    = (pt == PT_THREAD) &
    ((addr_q[11:0] & TCS_OFFSET_MASK) != (TCS_FLAGS_OFFSET & TCS_OFFSET_MASK)); // [R10]
  wire        dbg_off    = ~MAP_ENTRY.debug; // [R11]
  // Permission bits of the entry are deliberately left unread
  wire [2:0]  rwx_unused = MAP_ENTRY.rwx; // [R14]

  // First failing check wins
  dew_outcome_e outcome;
  always_comb begin
    if (canon_bad | seg_bad | align_bad) begin
      outcome = OUT_GP;
    end else if (not_cache) begin
      outcome = OUT_PF;
    end else if (conflict) begin
      outcome = OUT_GP;
    end else if (invalid | type_bad) begin
      outcome = OUT_PF;
    end else if (notdbg) begin
      outcome = OUT_NOTDBG;
    end else if (tcs_bad | dbg_off) begin
      outcome = OUT_GP;
    end else begin
      outcome = OUT_OK;
    end
  end // [R18]

  // Byte enables and data follow the mode, never an operand size
  wire [7:0]  wr_be    = mode64 ? 8'hff : 8'h0f; // [R02]
  wire [63:0] wr_data  = mode64 ? data_q : {32'h0, data_q[31:0]}; // [R02]
  wire        wr_done  = (state_q == ST_WRITE) & MEM_WR_READY;
  wire        finish   = ((state_q == ST_LOOK) & (outcome != OUT_OK)) | wr_done;
  wire        ev_gp    = (state_q == ST_LOOK) & (outcome == OUT_GP);
  wire        ev_pf    = (state_q == ST_LOOK) & (outcome == OUT_PF);
  wire        ev_done  = finish & ~ev_gp & ~ev_pf;
  wire [IRQ_W-1:0] ev_vec = {ev_pf, ev_gp, ev_done};
  wire [IRQ_W-1:0] clr_vec = wr_iclr ? WB_DAT_I[IRQ_W-1:0] : {IRQ_W{1'b0}};

  // ------------------------------------------------------------
  // Operation sequencer
  // ------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      state_q    <= ST_IDLE;
      busy_q     <= 1'b0;
      wr_valid_q <= 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (go & leaf_ok) begin
            state_q <= ST_LOOK;
            busy_q  <= 1'b1;
          end
        end
        ST_LOOK: begin
          if (outcome == OUT_OK) begin
            state_q    <= ST_WRITE;
            wr_valid_q <= 1'b1;
          end else begin
            state_q <= ST_IDLE; // [R18]
            busy_q  <= 1'b0;
          end
        end
        ST_WRITE: begin
          if (MEM_WR_READY) begin
            state_q    <= ST_IDLE;
            wr_valid_q <= 1'b0;
            busy_q     <= 1'b0;
          end
        end
      endcase
    end
  end

  // Result, flags and fault reporting
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      result_q <= 64'h0;
      flags_q  <= '0;
      gp_q     <= 1'b0;
      pf_q     <= 1'b0;
    end else if (go & leaf_ok) begin
      gp_q <= 1'b0;
      pf_q <= 1'b0;
    end else if (ev_gp) begin
      gp_q <= 1'b1;
    end else if (ev_pf) begin
      pf_q <= 1'b1;
    end else if (finish) begin
      result_q <= wr_done ? 64'h0 : PAGE_NOT_DEBUGGABLE; // [R09] [R12]
      flags_q  <= '{zf: ~wr_done, default: 1'b0}; // [R12] [R13]
    end
  end

  // Operand registers, interrupt registers and bus answer
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      leaf_q     <= 32'h0;
      addr_q     <= 64'h0;
      data_q     <= 64'h0;
      mode_q     <= MODE_RST;
      irq_stat_q <= '0;
      irq_en_q   <= IRQ_EN_RST;
      ack_q      <= 1'b0;
      rdata_q    <= 32'h0;
    end else begin
      ack_q   <= bus_req;
      rdata_q <= rd_mux;
      if (wr_leaf & op_wr_ok) leaf_q <= lane_merge(leaf_q, WB_DAT_I, WB_SEL_I);
      if (wr_alo & op_wr_ok) addr_q[31:0] <= lane_merge(addr_q[31:0], WB_DAT_I, WB_SEL_I);
      if (wr_ahi & op_wr_ok) addr_q[63:32] <= lane_merge(addr_q[63:32], WB_DAT_I, WB_SEL_I);
      if (wr_dlo & op_wr_ok) data_q[31:0] <= lane_merge(data_q[31:0], WB_DAT_I, WB_SEL_I);
      if (wr_dhi & op_wr_ok) data_q[63:32] <= lane_merge(data_q[63:32], WB_DAT_I, WB_SEL_I);
      if (wr_mode & op_wr_ok & WB_SEL_I[0]) mode_q <= WB_DAT_I[2:0];
      if (wr_ien & WB_SEL_I[0]) irq_en_q <= WB_DAT_I[IRQ_W-1:0];
      // A new event wins over a clear in the same cycle
      irq_stat_q <= (irq_stat_q & ~clr_vec) | ev_vec;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign WB_ACK_O      = ack_q;
  assign WB_DAT_O      = rdata_q;
  assign MAP_ADDR      = addr_q;
  assign MAP_SHARED    = (state_q == ST_LOOK); // [R06]
  assign MEM_WR_VALID  = wr_valid_q; // [R18]
  assign MEM_WR        = '{addr: addr_q, data: wr_data, be: wr_be};
  assign FLAGS         = flags_q;
  assign GP_FAULT      = gp_q;
  assign PF_FAULT      = pf_q;
  assign PF_ADDR       = addr_q; // [R05] [R07]
  assign IRQ           = |(irq_stat_q & irq_en_q);

endmodule
`default_nettype wire

//--- shared/dew_pkg.sv
// Package for the debug enclave write leaf: constants, types, register map
// Operation
// [R01] Leaf 05H of the supervisor enclave op selects the debug enclave write.
// [R02] Write eight bytes in 64-bit mode, else four low bytes; no override.
// [R03] 64-bit mode only when long mode active and code long bit both set.
// [R04] Misaligned target (8 in 64-bit, 4 otherwise) gives protection fault zero.
// [R05] Target outside the enclave page cache gives page fault with address.
// [R06] Take shared map entry access; concurrent modifier gives protection fault.
// [R07] Map entry valid bit clear gives page fault with target address.
// [R08] Page type not regular, thread, or shadow stack gives page fault.
// [R09] Pending or modified page: set zero flag, not-debuggable code, skip write.
// [R10] Thread page offset masked FF8H must equal flags word offset, else fault.
// [R11] Owning control structure debug attribute zero gives protection fault.
// [R12] Success sets result register zero and clears zero flag.
// [R13] Completion clears carry, parity, aux carry, overflow and sign flags.
// [R14] Map entry read, write and execute permissions are never checked.
// [R15] Target in an enclave control structure page faults.
// [R16] Non-canonical target in 64-bit mode gives protection fault zero.
// [R17] Outside 64-bit, unusable or violated data segment gives protection fault.
// [R18] Checks in order; first failure ends; no memory change on fault or error.
package dew_pkg;

  // ------------------------------------------------------------
  // Operation encodings
  // ------------------------------------------------------------
  localparam logic [31:0] LEAF_DEBUG_WRITE      = 32'h0000_0005;
  localparam logic [63:0] PAGE_NOT_DEBUGGABLE   = 64'h0000_0000_0000_000b;
  localparam logic [11:0] TCS_OFFSET_MASK       = 12'hff8;
  localparam logic [11:0] TCS_FLAGS_OFFSET      = 12'h008;
  localparam int          CANON_BITS            = 48;

  // Page types held in the map entry
  localparam logic [2:0]  PT_REGULAR            = 3'h1;
  localparam logic [2:0]  PT_THREAD             = 3'h2;
  localparam logic [2:0]  PT_CONTROL            = 3'h0;
  localparam logic [2:0]  SHADOW_STACK_FIRST_TYPE_CODE      = 3'h5;
  localparam logic [2:0]  SHADOW_STACK_REST_TYPE_CODE       = 3'h6;

  // ------------------------------------------------------------
  // Wishbone register map (word offsets as byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0]  REG_CTRL              = 8'h00;
  localparam logic [7:0]  REG_LEAF              = 8'h04;
  localparam logic [7:0]  REG_ADDR_LO           = 8'h08;
  localparam logic [7:0]  REG_ADDR_HI           = 8'h0c;
  localparam logic [7:0]  REG_DATA_LO           = 8'h10;
  localparam logic [7:0]  REG_DATA_HI           = 8'h14;
  localparam logic [7:0]  REG_MODE              = 8'h18;
  localparam logic [7:0]  REG_RESULT_LO         = 8'h1c;
  localparam logic [7:0]  REG_RESULT_HI         = 8'h20;
  localparam logic [7:0]  REG_STATUS            = 8'h24;
  localparam logic [7:0]  REG_IRQ_STAT          = 8'h28;
  localparam logic [7:0]  REG_IRQ_EN            = 8'h2c;
  localparam logic [7:0]  REG_IRQ_CLR           = 8'h30;

  // Bit positions
  localparam int          CTRL_GO_BIT           = 0;
  localparam int          MODE_LMA_BIT          = 0;
  localparam int          MODE_CSL_BIT          = 1;
  localparam int          MODE_DSOK_BIT         = 2;
  localparam int          IRQ_DONE_BIT          = 0;
  localparam int          IRQ_GP_BIT            = 1;
  localparam int          IRQ_PF_BIT            = 2;
  localparam int          IRQ_W                 = 3;

  // Reset values
  localparam logic [2:0]  MODE_RST              = 3'h7;
  localparam logic [IRQ_W-1:0] IRQ_EN_RST       = 3'h0;

  // Operation outcome
  typedef enum logic [1:0] {
    OUT_OK,
    OUT_NOTDBG,
    OUT_GP,
    OUT_PF
  } dew_outcome_e;

  // Page map entry as seen from the lookup port
  typedef struct packed {
    logic       in_cache;
    logic       valid;
    logic [2:0] ptype;
    logic       pending;
    logic       modified;
    logic [2:0] rwx;
    logic       debug;
  } dew_entry_s;

  // Memory write request toward enclave memory
  typedef struct packed {
    logic [63:0] addr;
    logic [63:0] data;
    logic [7:0]  be;
  } dew_wr_s;

  // Flag outputs of the leaf
  typedef struct packed {
    logic zf;
    logic cf;
    logic pf;
    logic af;
    logic of;
    logic sf;
  } dew_flags_s;

endpackage

//--- tb/dew_far_model.sv
// Far side model: page map lookup and enclave memory port
`timescale 1ns/10ps
`default_nettype none
module dew_far_model (
  // Clock and reset
  input  wire logic                mclk,
  input  wire logic                rst,
  // Lookup
  input  wire logic                map_shared,
  output dew_pkg::dew_entry_s      map_entry,
  output logic                     map_busy,
  output logic                     seg_fault,
  // Memory write
  input  wire logic                wr_valid,
  input  wire dew_pkg::dew_wr_s    wr,
  output logic                     wr_ready,
  // Bench set-up and log
  input  wire dew_pkg::dew_entry_s cfg_entry,
  input  wire logic                cfg_busy,
  input  wire logic                cfg_seg,
  input  wire logic [1:0]          cfg_stall,
  output int                       wr_cnt,
  output dew_pkg::dew_wr_s         wr_last
);
  import dew_pkg::*;
  logic [1:0] wait_q;
  // Entry is garbage unless the lookup is held, so stale reads show up
  assign map_entry = map_shared ? cfg_entry : dew_entry_s'(~cfg_entry);
  assign map_busy  = cfg_busy;
  assign seg_fault = cfg_seg;
  assign wr_ready  = wr_valid && (wait_q >= cfg_stall);
  // Stall count restarts per write: prompt and slow answers both occur
  always_ff @(posedge mclk) begin
    if (rst || !wr_valid || wr_ready) wait_q <= 2'h0;
    else wait_q <= wait_q + 2'h1;
    if (rst) wr_cnt <= 0;
    else if (wr_valid && wr_ready) begin
      wr_cnt  <= wr_cnt + 1;
      wr_last <= wr;
    end
  end
endmodule
`default_nettype wire

//--- tb/dew_props.sv
// Port checker for the debug enclave write leaf
`timescale 1ns/10ps
`default_nettype none
module dew_props (
  // Clock and reset
  input wire logic                MCLK,
  input wire logic                SYS_RST,
  // Lookup side
  input wire logic [63:0]         MAP_ADDR,
  input wire dew_pkg::dew_entry_s MAP_ENTRY,
  input wire logic                MAP_BUSY,
  input wire logic                MAP_SHARED,
  // Write side and results
  input wire logic                MEM_WR_VALID,
  input wire dew_pkg::dew_wr_s    MEM_WR,
  input wire logic                MEM_WR_READY,
  input wire dew_pkg::dew_flags_s FLAGS,
  input wire logic                GP_FAULT,
  input wire logic                PF_FAULT,
  input wire logic [63:0]         PF_ADDR
);
  import dew_pkg::*;
  // --------------------------------------
  // Properties
  // --------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);
  // Lookup cycle on a live regular page
  wire reg_ok = MAP_SHARED && MAP_ENTRY.in_cache && !MAP_BUSY && MAP_ENTRY.valid
                && MAP_ENTRY.ptype == PT_REGULAR;
  property p_wr_width;
    MEM_WR_VALID |-> MEM_WR.be == 8'hff || (MEM_WR.be == 8'h0f && MEM_WR.data[63:32] == 32'h0);
  endproperty
  a_wr_width: assert property (p_wr_width) else $error("bad write width");
  property p_wr_align;
    MEM_WR_VALID |-> ((MEM_WR.be == 8'hff) ? MEM_WR.addr[2:0] == 3'h0 : MEM_WR.addr[1:0] == 2'h0);
  endproperty
  a_wr_align: assert property (p_wr_align) else $error("misaligned write");
  property p_wr_hold;
    MEM_WR_VALID && !MEM_WR_READY |=> MEM_WR_VALID && $stable(MEM_WR);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write dropped");
  property p_pf_addr;
    $rose(PF_FAULT) |-> PF_ADDR == $past(MAP_ADDR) && $past(MAP_SHARED);
  endproperty
  a_pf_addr: assert property (p_pf_addr) else $error("page fault address");
  property p_conflict;
    MAP_SHARED && MAP_ENTRY.in_cache && MAP_BUSY |=> GP_FAULT && !PF_FAULT;
  endproperty
  a_conflict: assert property (p_conflict) else $error("conflict not refused");
  property p_ctrl_page;
    MAP_SHARED && MAP_ENTRY.in_cache && MAP_ENTRY.ptype == PT_CONTROL |=> !MEM_WR_VALID [*2];
  endproperty
  a_ctrl_page: assert property (p_ctrl_page) else $error("control page written");
  property p_notdbg;
    reg_ok && (MAP_ENTRY.pending || MAP_ENTRY.modified) |=> GP_FAULT || FLAGS == 6'h20;
  endproperty
  a_notdbg: assert property (p_notdbg) else $error("not debuggable flags");
  property p_nodebug;
    reg_ok && !MAP_ENTRY.pending && !MAP_ENTRY.modified && !MAP_ENTRY.debug |=> GP_FAULT;
  endproperty
  a_nodebug: assert property (p_nodebug) else $error("non-debug enclave accepted");
  property p_done;
    MEM_WR_VALID && MEM_WR_READY |=> FLAGS == 6'h00 && !GP_FAULT && !PF_FAULT;
  endproperty
  a_done: assert property (p_done) else $error("completion flags");
  property p_fault_quiet;
    GP_FAULT || PF_FAULT |-> !MEM_WR_VALID;
  endproperty
  a_fault_quiet: assert property (p_fault_quiet) else $error("write after fault");
endmodule
bind dew_top dew_props u_props (.MCLK, .SYS_RST, .MAP_ADDR, .MAP_ENTRY, .MAP_BUSY, .MAP_SHARED,
  .MEM_WR_VALID, .MEM_WR, .MEM_WR_READY, .FLAGS, .GP_FAULT, .PF_FAULT, .PF_ADDR);
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench for the debug enclave write leaf
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import dew_pkg::*;
  logic mclk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, mshr, busy_o, seg_o;
  logic wv, wrdy, gp, pf, irq, cfg_b = 1'b0, cfg_s = 1'b0;
  logic [7:0] adr = 8'h00, xst = 8'h00;
  logic [31:0] wdat = 32'h0, rdat;
  logic [63:0] maddr, pf_addr, xres = 64'h0;
  logic [1:0] cfg_st = 2'h0;
  dew_entry_s ment, cfg_e = dew_entry_s'(11'h641);
  dew_wr_s wr, wr_last;
  dew_flags_s flags;
  int seed = 42, miscompares = 0, comparisons = 0, ncyc = 0, wr_cnt;
  dew_top uut (.MCLK(mclk), .SYS_RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .MAP_ADDR(maddr), .MAP_ENTRY(ment), .MAP_BUSY(busy_o), .SEG_FAULT(seg_o),
    .MAP_SHARED(mshr), .MEM_WR_VALID(wv), .MEM_WR(wr), .MEM_WR_READY(wrdy), .FLAGS(flags),
    .GP_FAULT(gp), .PF_FAULT(pf), .PF_ADDR(pf_addr), .IRQ(irq));
  dew_far_model u_far (.mclk(mclk), .rst(rst), .map_shared(mshr), .map_entry(ment),
    .map_busy(busy_o), .seg_fault(seg_o), .wr_valid(wv), .wr(wr), .wr_ready(wrdy),
    .cfg_entry(cfg_e), .cfg_busy(cfg_b), .cfg_seg(cfg_s), .cfg_stall(cfg_st),
    .wr_cnt(wr_cnt), .wr_last(wr_last));
  // --------------------------------------
  // Tasks and expectations
  // --------------------------------------
  initial begin
    forever #12.5 mclk = ~mclk;
  end
  task automatic chk(input string nm, input logic [63:0] x, input logic [63:0] g);
    comparisons++;
    if (g !== x) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, x, g);
    end
  endtask
  // Classic cycle: hold until ack, release at that edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge mclk);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1);
    q = rdat;
    {cyc, stb} <= 2'b00;
    chk("ack_wait", 2, n);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  function automatic dew_outcome_e exp_out(logic [2:0] m, logic [63:0] a, dew_entry_s e,
                                           logic b, logic s);
    if (m[0] & m[1] ? a[63:47] != {17{a[47]}} || a[2:0] != 0 : !m[2] || s || a[1:0] != 0)
      return OUT_GP;
    if (!e.in_cache) return OUT_PF;
    if (b) return OUT_GP;
    if (!e.valid || !(e.ptype inside {PT_REGULAR, PT_THREAD, SHADOW_STACK_FIRST_TYPE_CODE, SHADOW_STACK_REST_TYPE_CODE}))
      return OUT_PF;
    if (e.pending || e.modified) return OUT_NOTDBG;
    if (e.ptype == PT_THREAD && (a[11:0] & TCS_OFFSET_MASK) != TCS_FLAGS_OFFSET) return OUT_GP;
    return e.debug ? OUT_OK : OUT_GP;
  endfunction
  task automatic op(input logic [2:0] m, input logic [63:0] a, input logic [10:0] e,
                    input logic b, input logic s);
    logic [63:0] d;
    logic [31:0] q, h;
    logic [2:0] en;
    dew_outcome_e x;
    int n0, i;
    d = {$random(seed), $random(seed)};
    en = 3'($random(seed));
    x = exp_out(m, a, dew_entry_s'(e), b, s);
    {cfg_e, cfg_b, cfg_s, cfg_st} <= {e, b, s, d[1:0]};
    wr_reg(REG_IRQ_EN, {29'h0, en});
    wr_reg(REG_MODE, {29'h0, m});
    wr_reg(REG_ADDR_LO, a[31:0]);
    wr_reg(REG_ADDR_HI, a[63:32]);
    wr_reg(REG_DATA_LO, d[31:0]);
    wr_reg(REG_DATA_HI, d[63:32]);
    wr_reg(REG_LEAF, LEAF_DEBUG_WRITE);
    n0 = wr_cnt;
    wr_reg(REG_CTRL, 32'h1);
    i = 0;
    do begin
      wb(1'b0, REG_STATUS, 32'h0, q);
      i++;
    end while (q[8] !== 1'b0 && i < 16);
    if (x == OUT_OK) {xres, xst} = {64'h0, 8'h00};
    if (x == OUT_NOTDBG) {xres, xst} = {PAGE_NOT_DEBUGGABLE, 8'h20};
    xst[7:6] = {x == OUT_PF, x == OUT_GP};
    chk("status", {1'b0, xst}, q[8:0]);
    chk("pins", xst, {pf, gp, flags});
    wb(1'b0, REG_RESULT_LO, 32'h0, q);
    wb(1'b0, REG_RESULT_HI, 32'h0, h);
    chk("result", xres, {h, q});
    chk("writes", n0 + (x == OUT_OK), wr_cnt);
    chk("map_addr", a, maddr);
    if (x == OUT_OK) begin
      chk("wr_addr", a, wr_last.addr);
      chk("wr_data", (m[0] & m[1]) ? d : {32'h0, d[31:0]}, wr_last.data);
      chk("wr_be", (m[0] & m[1]) ? 8'hff : 8'h0f, wr_last.be);
    end
    if (x == OUT_PF) chk("pf_addr", a, pf_addr);
    wb(1'b0, REG_IRQ_STAT, 32'h0, q);
    h = (x == OUT_GP) ? 32'h2 : (x == OUT_PF) ? 32'h4 : 32'h1;
    chk("irq_stat", {|(h[2:0] & en), h}, {irq, q});
    wr_reg(REG_IRQ_CLR, 32'h7);
    wb(1'b0, REG_IRQ_STAT, 32'h0, q);
    chk("irq_clr", 0, {irq, q});
  endtask
  task automatic end_sim;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Hang guard, well above the expected run length
  always @(posedge mclk) begin
    ncyc++;
    if (ncyc == 20000) begin
      miscompares++;
      end_sim;
    end
  end
  // --------------------------------------
  // Main sequence
  // --------------------------------------
  initial begin
    logic [31:0] q, r;
    logic [63:0] a;
    logic [10:0] e;
    logic [2:0] m;
    logic [2:0] mt [4];
    mt = '{3'h7, 3'h5, 3'h6, 3'h1};
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    wr_reg(8'hfc, 32'hdead_beef);
    wb(1'b0, 8'hfc, 32'h0, q);
    chk("unmapped", 0, q);
    wr_reg(REG_LEAF, 32'h4);
    wr_reg(REG_CTRL, 32'h1);
    wb(1'b0, REG_STATUS, 32'h0, q);
    chk("other_leaf", {wr_cnt, 9'h0}, {32'h0, q[8:0]});
    op(3'h7, 64'h1000, 11'h64f, 1'b0, 1'b0);
    op(3'h5, 64'h1004, 11'h641, 1'b0, 1'b0);
    op(3'h6, 64'h100c, 11'h681, 1'b0, 1'b0);
    op(3'h7, 64'h1004, 11'h641, 1'b0, 1'b0);
    op(3'h5, 64'h1002, 11'h641, 1'b0, 1'b0);
    op(3'h7, 64'h0000_8000_0000_1000, 11'h641, 1'b0, 1'b0);
    op(3'h1, 64'h1000, 11'h641, 1'b0, 1'b0);
    op(3'h5, 64'h1000, 11'h641, 1'b0, 1'b1);
    op(3'h7, 64'h1000, 11'h241, 1'b0, 1'b0);
    op(3'h7, 64'h1000, 11'h641, 1'b1, 1'b0);
    op(3'h7, 64'h1000, 11'h441, 1'b0, 1'b0);
    op(3'h7, 64'h1000, 11'h601, 1'b0, 1'b0);
    op(3'h7, 64'h1000, 11'h6c1, 1'b0, 1'b0);
    op(3'h7, 64'h1000, 11'h741, 1'b0, 1'b0);
    op(3'h7, 64'h1000, 11'h781, 1'b0, 1'b0);
    op(3'h7, 64'h1000, 11'h660, 1'b0, 1'b0);
    op(3'h7, 64'h1000, 11'h651, 1'b0, 1'b0);
    op(3'h7, 64'h1010, 11'h681, 1'b0, 1'b0);
    op(3'h7, 64'h1000, 11'h640, 1'b0, 1'b0);
    repeat (40) begin
      r = $random(seed);
      m = mt[r[1:0]];
      a = {$random(seed), $random(seed)};
      if (m == 3'h7) a[63:48] = (r[6:4] == 3'h0) ? a[63:48] : {16{a[47]}};
      else a[63:32] = 32'h0;
      if (r[8:7] != 2'h0) a[2:0] = 3'h0;
      if (r[9]) a[11:3] = 9'h001;
      e = 11'($random(seed));
      if (r[10]) e = (e & 11'h00e) | 11'h641;
      op(m, a, e, r[12] & r[13], (m != 3'h7) & r[14] & r[15]);
    end
    end_sim;
  end
endmodule
`default_nettype wire
